// ### sac_pkg.sv
// shared constants for the serial converter control-word link
package sac_pkg;

	// ------------------------------------------------------------------
	// word layout
	// ------------------------------------------------------------------
	localparam int          WORD_W   = 8;
	localparam int          RES_W    = 12;
	localparam int          OUT_W    = 16;
	localparam int          CNT_W    = 5;
	localparam int          PAD_W    = 4;
	localparam int          SEL_HI   = 7;
	localparam int          SEL_LO   = 4;
	localparam int          LEN_HI   = 3;
	localparam int          LEN_LO   = 2;
	localparam int          ORD_BIT  = 1;
	localparam int          FMT_BIT  = 0;

	// ------------------------------------------------------------------
	// selector and length codes
	// ------------------------------------------------------------------
	localparam logic [3:0]  SEL_LAST_CH = 4'ha;
	localparam logic [3:0]  SEL_HALF    = 4'hb;
	localparam logic [3:0]  SEL_REFN    = 4'hc;
	localparam logic [3:0]  SEL_REFP    = 4'hd;
	localparam logic [3:0]  SEL_PD      = 4'he;
	localparam logic [1:0]  LEN_8       = 2'h1;
	localparam logic [1:0]  LEN_16      = 2'h3;
	localparam logic [1:0]  LEN_RESET   = 2'h0;
	localparam logic [CNT_W-1:0] NB_8   = 5'h08;
	localparam logic [CNT_W-1:0] NB_12  = 5'h0c;
	localparam logic [CNT_W-1:0] NB_16  = 5'h10;
	localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;
	localparam logic [CNT_W-1:0] SEL_FALL  = 5'h04;
	localparam logic [CNT_W-1:0] LEN_FALLS = 5'h05;
	localparam logic [CNT_W-1:0] WORD_BITS = 5'h08;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int          CLK_PERIOD_NS = 20;
	localparam int          CONV_TIME_NS  = 10000;
	localparam int          CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;

	// clocks in one transfer cycle for a length code
	function automatic logic [CNT_W-1:0] frame_bits(input logic [1:0] len);
		if (len == LEN_8) begin
			return NB_8;
		end else if (len == LEN_16) begin
			return NB_16;
		end
		return NB_12;
	endfunction

	function automatic logic [CNT_W-1:0] to_gray(input logic [CNT_W-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [CNT_W-1:0] from_gray(input logic [CNT_W-1:0] g);
		logic [CNT_W-1:0] b;
		b = g;
		// top bit passes as is, so the loop never indexes past it
		for (int i = CNT_W - 2; i >= 0; i--) begin
			b[i] = g[i] ^ b[i+1];
		end
		return b;
	endfunction

endpackage

// ### sac_link_if.sv
// serial link between host and converter: select, clock, data, done flag
`timescale 1ns/100ps
`default_nettype none
interface sac_link_if;
	logic csN;       // select, active low
	logic ioClk;     // serial clock made by the host
	logic dataIn;    // control word bits toward the device
	logic dataOut;   // result bits toward the host
	logic dataOutOe; // device drives dataOut while high
	logic eoc;       // conversion done flag, low while converting

	modport device (
		input  csN,
		input  ioClk,
		input  dataIn,
		output dataOut,
		output dataOutOe,
		output eoc
	);

	modport host (
		output csN,
		output ioClk,
		output dataIn,
		input  dataOut,
		input  dataOutOe,
		input  eoc
	);
endinterface
`default_nettype wire

// ### sac_device.sv
// converter end: control word capture, cycle sequencing, conversion timing
`timescale 1ns/100ps
`default_nettype none
// How it works
// (R1) word enters msb first, rising clock edges
// (R2) selector codes 0..10 pick external inputs
// (R3) codes 11..13 pick internal test voltages
// (R4) new selector serves the following conversion
// (R5) length bits set their own cycle length
// (R6) lengths 00/10 give twelve-clock cycle
// (R7) length 11 gives sixteen clocks, zero pads
// (R8) length 01 gives eight clocks, upper bits
// (R9) host gives exactly the selected clock count
// (R10) length takes effect at sixth rising edge
// (R11) sampling starts at fourth falling edge
// (R12) sampling holds at last falling edge
// (R13) done flag drops fixed delay after end
// (R14) host holds data steady until done
// (R15) host should prefer twelve-bit length
// (R16) code 14 powers down until other code
// (R17) order bit sets next output order
// (R18) format bit picks unsigned or signed
// (R19) input ignored after first eight clocks
// (R20) falling edges counted against latched length
module sac_device #(
	parameter int CONV_CYC = sac_pkg::CONV_CYC
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	sac_link_if.device       link,
	input  wire logic [11:0] adcCode,
	output logic      [3:0]  chanSel,
	output logic             sampling,
	output logic             powerDown
);
	localparam int CC_W = $clog2(CONV_CYC + 1);
	localparam logic [CC_W-1:0] CONV_LOAD = CC_W'(CONV_CYC - 1);

	// ------------------------------------------------------------------
	// link domain, clocked by the host serial clock
	// ------------------------------------------------------------------
	// select high holds the shift and count logic in reset, since the clock stops
	wire linkRstN = rstn & ~link.csN;

	logic [sac_pkg::WORD_W-1:0] shift_r;
	logic [sac_pkg::WORD_W-1:0] cfg_r;
	logic [1:0]                 lenSel_r;
	logic [sac_pkg::CNT_W-1:0]  fallCnt_r;
	logic [sac_pkg::CNT_W-1:0]  fallGray_r;
	logic [3:0]                 sel_r;
	logic                       samp_r;
	logic                       startTgl_r;
	logic                       pd_r;

	wire [sac_pkg::CNT_W-1:0] fallNxt  = fallCnt_r + sac_pkg::CNT_ONE;
	wire [sac_pkg::CNT_W-1:0] frameLen = sac_pkg::frame_bits(lenSel_r);
	wire                      frameEnd = (fallNxt == frameLen); // R20
	wire                      selFall  = (fallNxt == sac_pkg::SEL_FALL);
	wire [3:0]                selRx    = shift_r[3:0];
	wire                      wordOpen = (fallCnt_r < sac_pkg::WORD_BITS);

	// rising edges: shift in the word, then latch length at the sixth
	always_ff @(posedge link.ioClk or negedge linkRstN) begin
		if (!linkRstN) begin
			shift_r  <= '0;
			lenSel_r <= sac_pkg::LEN_RESET;
		end else begin
			if (wordOpen) begin
				shift_r <= {shift_r[6:0], link.dataIn}; // R1 R19
			end
			if (fallCnt_r == sac_pkg::LEN_FALLS) begin
				lenSel_r <= {shift_r[0], link.dataIn}; // R5 R10
			end
		end
	end

	// falling edges: count, open sampling, close the cycle
	always_ff @(negedge link.ioClk or negedge linkRstN) begin
		if (!linkRstN) begin
			fallCnt_r  <= '0;
			fallGray_r <= '0;
			samp_r     <= 1'b0;
			sel_r      <= '0;
		end else if (frameEnd) begin
			fallCnt_r  <= '0;   // R6 R7 R8
			fallGray_r <= '0;
			samp_r     <= 1'b0; // R12
		end else begin
			fallCnt_r  <= fallNxt;
			fallGray_r <= sac_pkg::to_gray(fallNxt);
			if (selFall) begin
				sel_r  <= selRx;
				samp_r <= (selRx != sac_pkg::SEL_PD); // R11
			end
		end
	end

	// end-of-cycle hand-off survives select cycling, so only rstn clears it
	always_ff @(negedge link.ioClk or negedge rstn) begin
		if (!rstn) begin
			cfg_r      <= '0;
			startTgl_r <= 1'b0;
			pd_r       <= 1'b1; // starts powered down
		end else begin
			if (frameEnd && linkRstN) begin
				cfg_r      <= shift_r;     // R4
				startTgl_r <= ~startTgl_r; // R6 R7 R8
			end
			if (selFall && linkRstN) begin
				pd_r <= (selRx == sac_pkg::SEL_PD); // R16
			end
		end
	end

	// ------------------------------------------------------------------
	// system domain: synchronisers
	// ------------------------------------------------------------------
	logic [1:0]                startSync_r;
	logic [1:0]                pdSync_r;
	logic [1:0]                sampSync_r;
	logic [1:0]                csSync_r;
	logic [3:0]                selSync0_r;
	logic [3:0]                selSync1_r;
	logic [sac_pkg::CNT_W-1:0] idxSync0_r;
	logic [sac_pkg::CNT_W-1:0] idxSync1_r;

	// selector and index are quasi-static or gray, so plain flops suffice
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			startSync_r <= '0;
			pdSync_r    <= 2'h3;
			sampSync_r  <= '0;
			csSync_r    <= 2'h3;
			selSync0_r  <= '0;
			selSync1_r  <= '0;
			idxSync0_r  <= '0;
			idxSync1_r  <= '0;
		end else begin
			startSync_r <= {startSync_r[0], startTgl_r};
			pdSync_r    <= {pdSync_r[0], pd_r};
			sampSync_r  <= {sampSync_r[0], samp_r};
			csSync_r    <= {csSync_r[0], link.csN};
			selSync0_r  <= sel_r;
			selSync1_r  <= selSync0_r;
			idxSync0_r  <= fallGray_r;
			idxSync1_r  <= idxSync0_r;
		end
	end

	// ------------------------------------------------------------------
	// system domain: conversion timing and result
	// ------------------------------------------------------------------
	logic                      startSeen_r;
	logic                      eoc_r;
	logic [CC_W-1:0]           convCnt_r;
	logic                      fmtPend_r;
	logic                      lsbPend_r;
	logic [1:0]                lenPend_r;
	logic [sac_pkg::OUT_W-1:0] outWord_r;
	logic                      outLsb_r;
	logic [1:0]                outLen_r;
	logic                      dataOut_r;
	logic                      oe_r;

	wire startEdge = startSync_r[1] ^ startSeen_r;
	wire cfgPd     =
		(cfg_r[sac_pkg::SEL_HI:sac_pkg::SEL_LO] == sac_pkg::SEL_PD);
	wire convDone  = ~eoc_r && (convCnt_r == '0);
	// signed form only flips the top bit
	wire [sac_pkg::RES_W-1:0] resFmt =
		fmtPend_r ? {~adcCode[11], adcCode[10:0]} : adcCode; // R18

	// output bit selection, numbers kept left-justified in outWord_r
	wire [sac_pkg::CNT_W-1:0] idx    = sac_pkg::from_gray(idxSync1_r);
	wire [sac_pkg::CNT_W-1:0] outN   = sac_pkg::frame_bits(outLen_r);
	wire [sac_pkg::CNT_W-1:0] posLsb = sac_pkg::NB_16 - outN + idx;
	wire [sac_pkg::CNT_W-1:0] posMsb =
		(sac_pkg::NB_16 - sac_pkg::CNT_ONE) - idx;
	wire [3:0]                pos    = outLsb_r ? posLsb[3:0] : posMsb[3:0];
	wire                      bitNxt =
		(eoc_r && idx < outN) ? outWord_r[pos] : 1'b0;

	// conversion start, countdown and settings latch
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			startSeen_r <= 1'b0;
			eoc_r       <= 1'b1;
			convCnt_r   <= '0;
			fmtPend_r   <= 1'b0;
			lsbPend_r   <= 1'b0;
			lenPend_r   <= sac_pkg::LEN_RESET;
		end else begin
			startSeen_r <= startSync_r[1];
			if (startEdge && !cfgPd && eoc_r) begin
				eoc_r     <= 1'b0;      // R13
				convCnt_r <= CONV_LOAD;
				fmtPend_r <= cfg_r[sac_pkg::FMT_BIT]; // R18
				lsbPend_r <= cfg_r[sac_pkg::ORD_BIT]; // R17
				lenPend_r <= cfg_r[sac_pkg::LEN_HI:sac_pkg::LEN_LO];
			end else if (convDone) begin
				eoc_r <= 1'b1;
			end else if (!eoc_r) begin
				convCnt_r <= convCnt_r - 1'b1;
			end
		end
	end

	// result register; 8-bit length reads only the upper bits
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			outWord_r <= '0;
			outLsb_r  <= 1'b0;
			outLen_r  <= sac_pkg::LEN_RESET;
		end else if (convDone) begin
			outWord_r <= {resFmt, {sac_pkg::PAD_W{1'b0}}}; // R7 R8
			outLsb_r  <= lsbPend_r; // R17
			outLen_r  <= lenPend_r; // R6 R7 R8
		end
	end

	// pins and user side, all registered; output forced low while converting
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dataOut_r <= 1'b0;
			oe_r      <= 1'b0;
			chanSel   <= '0;
			sampling  <= 1'b0;
			powerDown <= 1'b1;
		end else begin
			dataOut_r <= bitNxt;
			oe_r      <= ~csSync_r[1];
			chanSel   <= selSync1_r;    // R2 R3
			sampling  <= sampSync_r[1]; // R11 R12
			powerDown <= pdSync_r[1];   // R16
		end
	end

	assign link.dataOut   = dataOut_r;
	assign link.dataOutOe = oe_r;
	assign link.eoc       = eoc_r;
endmodule
`default_nettype wire

// ### sac_host.sv
// host end: drives select, divided serial clock and control word
`timescale 1ns/100ps
`default_nettype none
module sac_host #(
	parameter int HALF  = 8,
	parameter int SETUP = 4
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	sac_link_if.host         link,
	input  wire logic        start,
	input  wire logic [7:0]  ctrlWord,
	output logic             busy,
	output logic      [15:0] rxWord,
	output logic      [4:0]  rxLen,
	output logic             rxValid
);
	typedef enum {ST_IDLE, ST_SETUP, ST_LO, ST_HI, ST_WLO, ST_WHI} sac_hst_e;
	localparam int DV_W = $clog2(HALF + SETUP + 1);
	localparam logic [DV_W-1:0] HALF_LOAD  = DV_W'(HALF - 1);
	localparam logic [DV_W-1:0] SETUP_LOAD = DV_W'(SETUP);

	sac_hst_e                  state_r;
	logic [DV_W-1:0]           div_r;
	logic [7:0]                tx_r;
	logic [sac_pkg::CNT_W-1:0] nbits_r;
	logic [sac_pkg::CNT_W-1:0] bitCnt_r;
	logic                      pdSel_r;
	logic                      ioClk_r;
	logic                      csN_r;
	logic                      dataIn_r;
	logic [1:0]                eocSync_r;
	logic [1:0]                doutSync_r;

	wire                      divZero = (div_r == '0);
	wire [sac_pkg::CNT_W-1:0] bitNxt  = bitCnt_r + sac_pkg::CNT_ONE;
	wire                      lastBit = (bitNxt == nbits_r);
	wire                      moreTx  = (bitNxt < sac_pkg::WORD_BITS);
	// fields of the requested word
	wire [1:0]                reqLen  =
		ctrlWord[sac_pkg::LEN_HI:sac_pkg::LEN_LO];
	wire [3:0]                reqSel  =
		ctrlWord[sac_pkg::SEL_HI:sac_pkg::SEL_LO];

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			eocSync_r  <= 2'h3;
			doutSync_r <= '0;
		end else begin
			eocSync_r  <= {eocSync_r[0], link.eoc};
			doutSync_r <= {doutSync_r[0], link.dataOut};
		end
	end

	// ------------------------------------------------------------------
	// transfer sequencer
	// ------------------------------------------------------------------
	// clock count follows the length just sent; data held after the word
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r  <= ST_IDLE;
			div_r    <= '0;
			tx_r     <= '0;
			nbits_r  <= sac_pkg::NB_12;
			bitCnt_r <= '0;
			pdSel_r  <= 1'b0;
			ioClk_r  <= 1'b0;
			csN_r    <= 1'b1;
			dataIn_r <= 1'b0;
			busy     <= 1'b0;
			rxWord   <= '0;
			rxLen    <= '0;
			rxValid  <= 1'b0;
		end else begin
			rxValid <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (start) begin
						tx_r     <= ctrlWord;
						dataIn_r <= ctrlWord[sac_pkg::WORD_W-1]; // R1
						nbits_r  <= sac_pkg::frame_bits(reqLen); // R9
						pdSel_r  <= (reqSel == sac_pkg::SEL_PD);
						bitCnt_r <= '0;
						rxWord   <= '0;
						csN_r    <= 1'b0;
						busy     <= 1'b1;
						div_r    <= SETUP_LOAD;
						state_r  <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					div_r <= div_r - 1'b1;
					if (divZero) begin
						div_r   <= HALF_LOAD;
						state_r <= ST_LO;
					end
				end
				ST_LO: begin
					div_r <= div_r - 1'b1;
					if (divZero) begin
						ioClk_r <= 1'b1;
						rxWord  <= {rxWord[14:0], doutSync_r[1]};
						div_r   <= HALF_LOAD;
						state_r <= ST_HI;
					end
				end
				ST_HI: begin
					div_r <= div_r - 1'b1;
					if (divZero) begin
						ioClk_r  <= 1'b0;
						bitCnt_r <= bitNxt;
						div_r    <= HALF_LOAD;
						if (moreTx) begin
							tx_r     <= {tx_r[6:0], 1'b0};
							dataIn_r <= tx_r[sac_pkg::WORD_W-2];
						end
						if (!lastBit) begin
							state_r <= ST_LO;
						end else if (pdSel_r) begin
							state_r <= ST_WHI; // no conversion follows
						end else begin
							state_r <= ST_WLO;
						end
					end
				end
				ST_WLO: begin
					if (!eocSync_r[1]) begin
						state_r <= ST_WHI;
					end
				end
				ST_WHI: begin
					if (eocSync_r[1]) begin // R14
						csN_r   <= 1'b1;
						busy    <= 1'b0;
						rxLen   <= nbits_r;
						rxValid <= 1'b1;
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	assign link.csN    = csN_r;
	assign link.ioClk  = ioClk_r;
	assign link.dataIn = dataIn_r;
endmodule
`default_nettype wire

// ### sac_link_chk.sv
// concurrent checks on the serial link between host and converter ends
`timescale 1ns/100ps
`default_nettype none
module sac_link_chk #(
	parameter int CONV_CYC = 500
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic csN,
	input wire logic ioClk,
	input wire logic dataIn,
	input wire logic dataOut,
	input wire logic dataOutOe,
	input wire logic eoc
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// ----------------------------------------------------------------
	// link trackers
	// ----------------------------------------------------------------
	logic        ioPrev_r;
	logic [4:0]  riseCnt_r;
	logic [4:0]  fallCnt_r;
	logic [7:0]  word_r;
	logic [1:0]  len_r;
	logic [15:0] lowCnt_r;

	// edges of the host clock seen in the system clock domain
	wire       ioRise   = ioClk & ~ioPrev_r;
	wire       ioFall   = ~ioClk & ioPrev_r;
	wire [4:0] nBits    = (len_r == 2'h1) ? 5'h08 :
		(len_r == 2'h3) ? 5'h10 : 5'h0c;
	wire       lastFall = ioFall && (fallCnt_r == nBits - 5'h01);
	wire       pdSel    = (word_r[7:4] == 4'he);

	// counters restart whenever select is high, like the device's own
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			riseCnt_r <= 5'h00;
			fallCnt_r <= 5'h00;
			len_r     <= 2'h3; // widest length until latched
		end else if (csN) begin
			riseCnt_r <= 5'h00;
			fallCnt_r <= 5'h00;
			len_r     <= 2'h3;
		end else begin
			riseCnt_r <= riseCnt_r + {4'h0, ioRise};
			fallCnt_r <= fallCnt_r + {4'h0, ioFall};
			if (ioRise && riseCnt_r == 5'h05) len_r <= {word_r[0], dataIn};
		end
	end

	// word capture and conversion length, msb first on rises
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ioPrev_r <= 1'b0;
			word_r   <= 8'h00;
			lowCnt_r <= 16'h0000;
		end else begin
			ioPrev_r <= ioClk;
			if (ioRise && riseCnt_r < 5'h08) word_r <= {word_r[6:0], dataIn};
			lowCnt_r <= eoc ? 16'h0000 : lowCnt_r + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	chk_eoc_falls_end: assert property (
		lastFall && !pdSel |-> ##[1:8] !eoc)
		else $error("done flag did not drop after last fall");
	chk_conv_time_len: assert property (
		$rose(eoc) |-> lowCnt_r == CONV_CYC)
		else $error("done flag low for wrong cycle count");
	chk_pd_no_conv: assert property (
		lastFall && pdSel |-> eoc[*8])
		else $error("conversion started in power down");
	chk_exact_clocks: assert property (
		$rose(csN) |-> fallCnt_r == nBits)
		else $error("cycle ended with wrong clock count");
	chk_no_extra_clk: assert property (
		ioFall |-> fallCnt_r < nBits)
		else $error("serial clock beyond cycle length");
	chk_din_steady: assert property (
		!eoc ##1 !eoc |-> $stable(dataIn))
		else $error("data input moved during conversion");
	chk_dout_zero_conv: assert property (
		!eoc [*2] |-> !dataOut)
		else $error("data output not zero while converting");
	chk_clock_idle_desel: assert property (
		csN |-> !ioClk)
		else $error("serial clock active while deselected");
	chk_oe_while_sel: assert property (
		!csN [*4] |-> dataOutOe)
		else $error("data output not enabled while selected");

	// main traffic kinds seen
	cover property (lastFall && nBits == 5'h08);
	cover property (lastFall && nBits == 5'h10);
	cover property (lastFall && pdSel);
	cover property ($rose(eoc) && dataOutOe);
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench: host and converter ends joined by the serial link
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) \
	begin \
		checks++; \
		if ((got) !== (ex)) begin \
			failCount++; \
			$display("ERROR %s expected %h seen %h", nm, ex, got); \
		end \
	end
module testbench;
	localparam int CONV  = 20;
	localparam int LIMIT = 20000;

	logic        clk;
	logic        rstn;
	logic        start;
	logic [7:0]  ctrlWord;
	logic [11:0] adcCode;
	logic        busy;
	logic [15:0] rxWord;
	logic [4:0]  rxLen;
	logic        rxValid;
	logic [3:0]  chanSel;
	logic        sampling;
	logic        powerDown;
	logic        sawSamp;
	logic [7:0]  prevW;
	logic [11:0] prevA;
	int          checks;
	int          failCount;
	int          cyc;

	// ----------------------------------------------------------------
	// clock, ends, checker
	// ----------------------------------------------------------------
	initial clk = 1'b0;
	always #10 clk = ~clk;

	sac_link_if link ();
	sac_device #(.CONV_CYC(CONV)) sac_device_i (
		.clk(clk), .rstn(rstn), .link(link), .adcCode(adcCode),
		.chanSel(chanSel), .sampling(sampling), .powerDown(powerDown));
	sac_host sac_host_i (
		.clk(clk), .rstn(rstn), .link(link), .start(start),
		.ctrlWord(ctrlWord), .busy(busy), .rxWord(rxWord),
		.rxLen(rxLen), .rxValid(rxValid));
	sac_link_chk #(.CONV_CYC(CONV)) sac_link_chk_i (
		.clk(clk), .rstn(rstn), .csN(link.csN), .ioClk(link.ioClk),
		.dataIn(link.dataIn), .dataOut(link.dataOut),
		.dataOutOe(link.dataOutOe), .eoc(link.eoc));

	// remembers whether sampling was seen during a transfer
	always @(posedge clk) begin
		if (sampling === 1'b1) sawSamp <= 1'b1;
	end

	// hang guard; ceiling far above eleven transfers
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			failCount++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// reference model
	// ----------------------------------------------------------------
	function automatic int nBits(input logic [7:0] w);
		return (w[3:2] == 2'h1) ? 8 : (w[3:2] == 2'h3) ? 16 : 12;
	endfunction

	// bits a cycle should read back, first bit at the top
	function automatic logic [15:0] expWord(input logic [7:0] w,
		input logic [11:0] a);
		logic [11:0] r;
		logic [15:0] m;
		logic [15:0] o;
		int          n;
		r = a ^ {w[0], 11'h000};
		n = nBits(w);
		m = (n == 8) ? {8'h00, r[11:4]} : (n == 16) ? {r, 4'h0} : {4'h0, r};
		o = m;
		if (w[1]) begin
			o = 16'h0000;
			for (int i = 0; i < n; i++) o[i] = m[n-1-i];
		end
		return o;
	endfunction

	// one whole cycle; optionally judge the previous result read back
	task automatic xfer(input logic [7:0] w, input logic [11:0] a,
		input bit judge);
		int          k;
		logic [15:0] msk;
		logic [15:0] expW;
		logic [15:0] seen;
		k = 0;
		msk = (16'h0001 << nBits(prevW)) - 16'h0001;
		while (busy !== 1'b0 && k < 2000) begin
			@(posedge clk);
			#1;
			k++;
		end
		start = 1'b1;
		ctrlWord = w;
		adcCode = a;
		sawSamp = 1'b0;
		@(posedge clk);
		#1;
		start = 1'b0;
		while (rxValid !== 1'b1 && k < 4000) begin
			@(posedge clk);
			#1;
			k++;
		end
		expW = expWord(prevW, prevA);
		seen = rxWord & msk;
		`CHK("rxValid", 1'b1, rxValid)
		`CHK("rxLen", 5'(nBits(w)), rxLen)
		`CHK("chanSel", w[7:4], chanSel)
		`CHK("powerDown", (w[7:4] == 4'he), powerDown)
		`CHK("sampling", (w[7:4] != 4'he), sawSamp)
		if (judge) `CHK("rxWord", expW, seen)
		prevW = w;
		prevA = a;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic tReset();
		rstn = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		`CHK("eoc", 1'b1, link.eoc)
		`CHK("csN", 1'b1, link.csN)
		`CHK("powerDown", 1'b1, powerDown)
		`CHK("busy", 1'b0, busy)
		rstn = 1'b1;
	endtask

	// twelve-bit cycles, both length codes, both orders and formats
	task automatic tTwelve();
		xfer(8'h30, 12'h5a3, 1'b0);
		xfer(8'hab, 12'h3c6, 1'b1);
		xfer(8'h20, 12'h0ff, 1'b1);
	endtask

	// length change to eight bits, then eight-bit results
	task automatic tEight();
		xfer(8'hb4, 12'h9e1, 1'b0);
		xfer(8'hc6, 12'h7f0, 1'b1);
		xfer(8'h77, 12'ha5c, 1'b1);
	endtask

	// sixteen-bit cycles with pad bits in both orders
	task automatic tSixteen();
		xfer(8'hdd, 12'h123, 1'b0);
		xfer(8'h0e, 12'h456, 1'b1);
		xfer(8'h1f, 12'h8c1, 1'b1);
	endtask

	// power down, then wake with another selector
	task automatic tPower();
		xfer(8'hec, 12'h000, 1'b1);
		xfer(8'h3d, 12'h6b2, 1'b0);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, failCount);
		if (failCount == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		start = 1'b0;
		ctrlWord = 8'h00;
		adcCode = 12'h000;
		sawSamp = 1'b0;
		prevW = 8'h00;
		prevA = 12'h000;
		checks = 0;
		failCount = 0;
		cyc = 0;
		tReset();
		tTwelve();
		tEight();
		tSixteen();
		tPower();
		report_and_stop();
	end
endmodule
`default_nettype wire
